// ==== atsm_consts.vh ====
//Contract
//[R1] registers at 37h, 38h, 39h, 3Ah
//[R2] version register returns fixed 8-bit revision code
//[R3] select: first pin 7:4, second 3:0
//[R4] select resets 00h, both pins floating
//[R5] 0000 float, 1010 high, 1011 low
//[R6] 0001 puts each pin's level DAC out
//[R7] 0010/0100/0101/0110 route analog signals through DAC
//[R8] 1100 outputs transmit-active indication
//[R9] 1101 outputs receive-active indication
//[R10] 1110 subcarrier detected, void at 106 kBd
//[R11] 1111 outputs chosen test bus bit
//[R12] second selector uses same code meanings
//[R13] first level register 6 bits, feeds DAC one
//[R14] second level register 6 bits, feeds DAC two
//[R15] software ignores level register bits 7:6
//[R16] writes to version register are ignored
`ifndef ATSM_CONSTS_VH
`define ATSM_CONSTS_VH

// register indices; byte address is four times the index
`define ATSM_IDX_VERSION 8'h37
`define ATSM_IDX_SELECT 8'h38
`define ATSM_IDX_LEVEL_ONE 8'h39
`define ATSM_IDX_LEVEL_TWO 8'h3a
`define ATSM_ADDR_VERSION 10'h0dc
`define ATSM_ADDR_SELECT 10'h0e0
`define ATSM_ADDR_LEVEL_ONE 10'h0e4
`define ATSM_ADDR_LEVEL_TWO 10'h0e8

// field positions
`define ATSM_SEL_FIRST_HI 7
`define ATSM_SEL_FIRST_LO 4
`define ATSM_SEL_SECOND_HI 3
`define ATSM_SEL_SECOND_LO 0
`define ATSM_LEVEL_HI 5

// reset values
`define ATSM_SELECT_RESET 8'h00
`define ATSM_LEVEL_RESET 6'h00
`define ATSM_VERSION_DEFAULT 8'h5a

// selector codes
`define ATSM_CODE_FLOAT 4'h0
`define ATSM_CODE_LEVEL_DAC 4'h1
`define ATSM_CODE_CORRELATOR 4'h2
`define ATSM_CODE_MIN_LEVEL 4'h4
`define ATSM_CODE_SAMPLE_I 4'h5
`define ATSM_CODE_SAMPLE_Q 4'h6
`define ATSM_CODE_HIGH 4'ha
`define ATSM_CODE_LOW 4'hb
`define ATSM_CODE_TX_ACTIVE 4'hc
`define ATSM_CODE_RX_ACTIVE 4'hd
`define ATSM_CODE_SUBCARRIER 4'he
`define ATSM_CODE_TEST_BUS 4'hf

`endif

// ==== atsm_aux_test_mux.v ====
`timescale 1ns/1ns
`include "atsm_consts.vh"

module atsm_aux_test_mux #(
    // arbitrary value, not any real part's code
    parameter [7:0] VERSION_CODE = `ATSM_VERSION_DEFAULT,
    parameter ADDR_WIDTH = 10
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // internal test sources
    input wire [5:0] correlator_test_signal,
    input wire [3:0] minimum_level_signal,
    input wire [3:0] sample_i,
    input wire [3:0] sample_q,
    input wire transmit_in_progress,
    input wire receive_in_progress,
    input wire subcarrier_detected,
    input wire rate_is_106,
    input wire [7:0] test_bus,
    input wire [2:0] test_bus_bit_choice,
    // level values toward the test dacs
    output wire [5:0] first_test_level,
    output wire [5:0] second_test_level,
    // first auxiliary pin
    output wire first_aux_output,
    output wire first_aux_oe,
    output wire [5:0] first_aux_dac_code,
    output wire first_aux_dac_en,
    // second auxiliary pin
    output wire second_aux_output,
    output wire second_aux_oe,
    output wire [5:0] second_aux_dac_code,
    output wire second_aux_dac_en
);

////////////////////////////////////////////////////////////////////////////////
// register state

reg [7:0] select_reg;
reg [5:0] level_one_reg;
reg [5:0] level_two_reg;
reg [31:0] prdata_reg;

wire [ADDR_WIDTH-1:0] addr_version;
wire [ADDR_WIDTH-1:0] addr_select;
wire [ADDR_WIDTH-1:0] addr_level_one;
wire [ADDR_WIDTH-1:0] addr_level_two;

assign addr_version = `ATSM_ADDR_VERSION;
assign addr_select = `ATSM_ADDR_SELECT;
assign addr_level_one = `ATSM_ADDR_LEVEL_ONE;
assign addr_level_two = `ATSM_ADDR_LEVEL_TWO;

////////////////////////////////////////////////////////////////////////////////
// address decode

wire hit_version;
wire hit_select;
wire hit_level_one;
wire hit_level_two;
wire hit_any;
wire setup_phase;
wire access_phase;
wire wr_lane0;

assign hit_version = (paddr == addr_version); // [R1]
assign hit_select = (paddr == addr_select); // [R1]
assign hit_level_one = (paddr == addr_level_one); // [R1]
assign hit_level_two = (paddr == addr_level_two); // [R1]
assign hit_any = hit_version | hit_select | hit_level_one | hit_level_two;

assign setup_phase = psel & ~penable;
assign access_phase = psel & penable;

// registers are one byte wide, so only lane 0 can change them
assign wr_lane0 = access_phase & pwrite & pstrb[0];

// zero wait states: every access ends in its first access cycle
assign pready = 1'h1;

// unmapped addresses answer with an error and change nothing
assign pslverr = access_phase & ~hit_any;

////////////////////////////////////////////////////////////////////////////////
// register writes

always @(posedge clock) begin
    if (!rst_b) begin
        select_reg <= `ATSM_SELECT_RESET; // [R4]
        level_one_reg <= `ATSM_LEVEL_RESET;
        level_two_reg <= `ATSM_LEVEL_RESET;
    end else if (wr_lane0) begin
        if (hit_select) begin
            select_reg <= pwdata[7:0]; // [R3]
        end
        if (hit_level_one) begin
            // upper two bits are not stored; software must not rely on them
            level_one_reg <= pwdata[`ATSM_LEVEL_HI:0]; // [R13] [R15]
        end
        if (hit_level_two) begin
            level_two_reg <= pwdata[`ATSM_LEVEL_HI:0]; // [R14] [R15]
        end
        // a write to the version index stores nothing [R16]
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data, captured in the setup cycle so it stands through access

reg [7:0] read_byte;

always @* begin
    read_byte = 8'h00;
    if (hit_version) begin
        read_byte = VERSION_CODE; // [R2] [R16]
    end else if (hit_select) begin
        read_byte = select_reg; // [R3]
    end else if (hit_level_one) begin
        read_byte = {2'h0, level_one_reg}; // [R13]
    end else if (hit_level_two) begin
        read_byte = {2'h0, level_two_reg}; // [R14]
    end
end

always @(posedge clock) begin
    if (!rst_b) begin
        prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
        prdata_reg <= {24'h00_0000, read_byte};
    end
end

assign prdata = prdata_reg;

////////////////////////////////////////////////////////////////////////////////
// level values go straight to the dacs

assign first_test_level = level_one_reg; // [R13]
assign second_test_level = level_two_reg; // [R14]

////////////////////////////////////////////////////////////////////////////////
// per-pin routing, same code table for both pins

wire [3:0] first_pin_signal_select;
wire [3:0] second_pin_signal_select;
wire test_bus_bit;

assign first_pin_signal_select = select_reg[`ATSM_SEL_FIRST_HI:`ATSM_SEL_FIRST_LO]; // [R3]
assign second_pin_signal_select = select_reg[`ATSM_SEL_SECOND_HI:`ATSM_SEL_SECOND_LO]; // [R3]
assign test_bus_bit = test_bus[test_bus_bit_choice]; // [R11]

// one decoder for both pins, so the two code tables cannot drift apart
atsm_pin_route #(
    .DAC_WIDTH(6)
) u_first_pin (
    .clock(clock),
    .rst_b(rst_b),
    .pin_signal_select(first_pin_signal_select),
    .pin_level(level_one_reg), // [R6]
    .correlator_test_signal(correlator_test_signal),
    .minimum_level_signal(minimum_level_signal),
    .sample_i(sample_i),
    .sample_q(sample_q),
    .transmit_in_progress(transmit_in_progress),
    .receive_in_progress(receive_in_progress),
    .subcarrier_detected(subcarrier_detected),
    .rate_is_106(rate_is_106),
    .test_bus_bit(test_bus_bit),
    .aux_output(first_aux_output),
    .aux_oe(first_aux_oe),
    .dac_code(first_aux_dac_code),
    .dac_en(first_aux_dac_en)
);

atsm_pin_route #(
    .DAC_WIDTH(6)
) u_second_pin (
    .clock(clock),
    .rst_b(rst_b),
    .pin_signal_select(second_pin_signal_select), // [R12]
    .pin_level(level_two_reg), // [R6]
    .correlator_test_signal(correlator_test_signal),
    .minimum_level_signal(minimum_level_signal),
    .sample_i(sample_i),
    .sample_q(sample_q),
    .transmit_in_progress(transmit_in_progress),
    .receive_in_progress(receive_in_progress),
    .subcarrier_detected(subcarrier_detected),
    .rate_is_106(rate_is_106),
    .test_bus_bit(test_bus_bit),
    .aux_output(second_aux_output),
    .aux_oe(second_aux_oe),
    .dac_code(second_aux_dac_code),
    .dac_en(second_aux_dac_en)
);

endmodule

////////////////////////////////////////////////////////////////////////////////
// one auxiliary pin: selector decode and registered pin controls

module atsm_pin_route #(
    parameter DAC_WIDTH = 6
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    // selector and level value for this pin
    input wire [3:0] pin_signal_select,
    input wire [DAC_WIDTH-1:0] pin_level,
    // shared test sources
    input wire [DAC_WIDTH-1:0] correlator_test_signal,
    input wire [3:0] minimum_level_signal,
    input wire [3:0] sample_i,
    input wire [3:0] sample_q,
    input wire transmit_in_progress,
    input wire receive_in_progress,
    input wire subcarrier_detected,
    input wire rate_is_106,
    input wire test_bus_bit,
    // pin controls
    output wire aux_output,
    output wire aux_oe,
    output wire [DAC_WIDTH-1:0] dac_code,
    output wire dac_en
);

////////////////////////////////////////////////////////////////////////////////
// 4-bit sources padded below to span the full dac range

wire [DAC_WIDTH-1:0] min_level_scaled;
wire [DAC_WIDTH-1:0] sample_i_scaled;
wire [DAC_WIDTH-1:0] sample_q_scaled;

assign min_level_scaled = {minimum_level_signal, {(DAC_WIDTH-4){1'h0}}}; // [R7]
assign sample_i_scaled = {sample_i, {(DAC_WIDTH-4){1'h0}}}; // [R7]
assign sample_q_scaled = {sample_q, {(DAC_WIDTH-4){1'h0}}}; // [R7]

////////////////////////////////////////////////////////////////////////////////
// code decode

reg out_next;
reg oe_next;
reg dac_en_next;
reg [DAC_WIDTH-1:0] dac_code_next;

always @* begin
    out_next = 1'h0;
    oe_next = 1'h0;
    dac_en_next = 1'h0;
    dac_code_next = {DAC_WIDTH{1'h0}};
    case (pin_signal_select)
        `ATSM_CODE_FLOAT: begin
            oe_next = 1'h0; // [R5]
        end
        `ATSM_CODE_LEVEL_DAC: begin
            dac_en_next = 1'h1; // [R6] [R12]
            dac_code_next = pin_level; // [R6]
        end
        `ATSM_CODE_CORRELATOR: begin
            dac_en_next = 1'h1; // [R7]
            dac_code_next = correlator_test_signal; // [R7]
        end
        `ATSM_CODE_MIN_LEVEL: begin
            dac_en_next = 1'h1; // [R7]
            dac_code_next = min_level_scaled; // [R7]
        end
        `ATSM_CODE_SAMPLE_I: begin
            dac_en_next = 1'h1; // [R7]
            dac_code_next = sample_i_scaled; // [R7]
        end
        `ATSM_CODE_SAMPLE_Q: begin
            dac_en_next = 1'h1; // [R7]
            dac_code_next = sample_q_scaled; // [R7]
        end
        `ATSM_CODE_HIGH: begin
            oe_next = 1'h1; // [R5]
            out_next = 1'h1; // [R5]
        end
        `ATSM_CODE_LOW: begin
            oe_next = 1'h1; // [R5]
            out_next = 1'h0; // [R5]
        end
        `ATSM_CODE_TX_ACTIVE: begin
            // framing of the indication is shaped by the transmitter
            oe_next = 1'h1; // [R8]
            out_next = transmit_in_progress; // [R8]
        end
        `ATSM_CODE_RX_ACTIVE: begin
            oe_next = 1'h1; // [R9]
            out_next = receive_in_progress; // [R9]
        end
        `ATSM_CODE_SUBCARRIER: begin
            // meaningless at 106 kBd, so held low there
            oe_next = 1'h1; // [R10]
            out_next = subcarrier_detected & ~rate_is_106; // [R10]
        end
        `ATSM_CODE_TEST_BUS: begin
            oe_next = 1'h1; // [R11]
            out_next = test_bus_bit; // [R11]
        end
        default: begin
            // reserved codes leave the pin floating as the safe choice
            oe_next = 1'h0; // [R5]
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// pin control flops

reg out_reg;
reg oe_reg;
reg dac_en_reg;
reg [DAC_WIDTH-1:0] dac_code_reg;

always @(posedge clock) begin
    if (!rst_b) begin
        out_reg <= 1'h0;
        oe_reg <= 1'h0; // [R4]
        dac_en_reg <= 1'h0; // [R4]
        dac_code_reg <= {DAC_WIDTH{1'h0}};
    end else begin
        out_reg <= out_next;
        oe_reg <= oe_next;
        dac_en_reg <= dac_en_next;
        dac_code_reg <= dac_code_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin outputs, one clock behind the selector and sources

assign aux_output = out_reg;
assign aux_oe = oe_reg;
assign dac_en = dac_en_reg;
assign dac_code = dac_code_reg;

endmodule

// ==== atsm_aux_probe.sv ====
`timescale 1ns/1ns
module atsm_aux_probe (
    // pin as seen by the instrument
    input wire logic oe,
    input wire logic drv,
    input wire logic dac_en,
    input wire logic [5:0] dac_code,
    output logic pin,
    output logic [5:0] amps
);
    // a 1k pull-down sits on the pin, so a floating pin reads low
    assign pin = oe ? drv : 1'b0;
    // current source is off unless enabled; no stale code leaks out
    assign amps = dac_en ? dac_code : 6'h00;
endmodule

// ==== atsm_aux_monitor.sv ====
`timescale 1ns/1ns
module atsm_aux_monitor #(parameter [7:0] VERSION_CODE = 8'h5a) (
    // clock, reset and bus
    input wire clock,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pslverr,
    // pin controls and first level value
    input wire first_aux_oe,
    input wire first_aux_output,
    input wire first_aux_dac_en,
    input wire second_aux_oe,
    input wire second_aux_dac_en,
    input wire [5:0] first_test_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire acc = psel && penable;
    wire wr = acc && pwrite && pstrb[0];
    wire wsel = wr && paddr == 10'h0e0;
    wire mapped = paddr >= 10'h0dc && paddr <= 10'h0e8 && paddr[1:0] == 2'b00;
    ////////////////////////////////////////////////////////////////
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    chk_sel_high: assert property (
        wsel && pwdata[7:4] == 4'ha |=> ##1 first_aux_oe && first_aux_output)
        else $error("high code not driven");
    chk_sel_low: assert property (
        wsel && pwdata[7:4] == 4'hb |=> ##1 first_aux_oe && !first_aux_output)
        else $error("low code not driven");
    chk_sel_float: assert property (
        wsel && pwdata[7:4] == 4'h0 |=> ##1 !first_aux_oe && !first_aux_dac_en)
        else $error("float code drives pin");
    chk_second_dac: assert property (
        wsel && pwdata[3:0] == 4'h1 |=> ##1 second_aux_dac_en && !second_aux_oe)
        else $error("second dac not routed");
    chk_level_store: assert property (
        wr && paddr == 10'h0e4 |=> first_test_level == $past(pwdata[5:0]))
        else $error("first level not stored");
    chk_version_read: assert property (
        acc && !pwrite && paddr == 10'h0dc |-> prdata == {24'h0, VERSION_CODE})
        else $error("version code wrong");
    chk_reset_float: assert property (
        $rose(rst_b) |-> !first_aux_oe && !second_aux_oe && !first_aux_dac_en)
        else $error("pins driven after reset");
    cover property (wsel && pwdata[7:4] == 4'ha);
    cover property (acc && !pwrite && paddr == 10'h0dc);
    cover property (acc && !mapped);
endmodule
bind atsm_aux_test_mux atsm_aux_monitor #(.VERSION_CODE(VERSION_CODE)) u_mon (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .first_aux_oe(first_aux_oe), .first_aux_output(first_aux_output),
    .first_aux_dac_en(first_aux_dac_en), .second_aux_oe(second_aux_oe),
    .second_aux_dac_en(second_aux_dac_en), .first_test_level(first_test_level));

// ==== test_aux_test_signal_mux.sv ====
`timescale 1ns/1ns
module test_aux_test_signal_mux;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, er;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic tx, rx, sub, r106, oe1, oe2, o1, o2, en1, en2, pin1, pin2;
    logic [2:0] choice;
    logic [5:0] c1, c2, a1, a2, corr, lvl1, lvl2;
    logic [3:0] minl, si, sq;
    logic [7:0] tbus;
    logic [23:0] rows [10];
    integer mismatches, total_checks, i;
    atsm_aux_test_mux i_dut (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .correlator_test_signal(corr), .minimum_level_signal(minl),
        .sample_i(si), .sample_q(sq), .transmit_in_progress(tx),
        .receive_in_progress(rx), .subcarrier_detected(sub), .rate_is_106(r106),
        .test_bus(tbus), .test_bus_bit_choice(choice), .first_test_level(lvl1),
        .second_test_level(lvl2), .first_aux_output(o1), .first_aux_oe(oe1),
        .first_aux_dac_code(c1), .first_aux_dac_en(en1), .second_aux_output(o2),
        .second_aux_oe(oe2), .second_aux_dac_code(c2), .second_aux_dac_en(en2));
    atsm_aux_probe p1 (.oe(oe1), .drv(o1), .dac_en(en1), .dac_code(c1), .pin(pin1), .amps(a1));
    atsm_aux_probe p2 (.oe(oe2), .drv(o2), .dac_en(en2), .dac_code(c2), .pin(pin2), .amps(a2));
    ////////////////////////////////////////////////////////////////
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one idle cycle between transfers keeps every signal single-driven per step
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        integer n;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1;
        n = 0;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clock);
        end
        if (n >= 20) mismatches++;
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task pins(input logic [23:0] r);
        repeat (2) @(posedge clock);
        #1;
        cmp("oe", r[15:14], {oe1, oe2});
        cmp("pin", r[13:12], {pin1, pin2});
        cmp("amps", r[11:0], {a1, a2});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clock);
        mismatches++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        mismatches = 0;
        total_checks = 0;
        {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {tx, rx, sub, r106, choice} = 7'h56;
        {corr, minl, si, sq, tbus} = {6'h2a, 4'h9, 4'h3, 4'h5, 8'h40};
        rows = '{24'h11056e, 24'h240aa4, 24'h560314, 24'habe000, 24'hcde000,
                 24'heff000, 24'h370000, 24'h890000, 24'ha0a000, 24'h000000};
        repeat (2) @(posedge clock);
        rst_b <= 1;
        apb(0, 10'h0e0, 0, 4'hf);
        cmp("select reset", 32'h0, rd);
        apb(1, 10'h0e4, 32'hd5, 4'h1);
        apb(1, 10'h0e8, 32'hee, 4'h1);
        apb(0, 10'h0e8, 0, 4'hf);
        cmp("level two", 32'h2e, rd);
        apb(0, 10'h0e4, 0, 4'hf);
        cmp("level one", 32'h15, rd);
        cmp("level one out", 32'h15, lvl1);
        cmp("level two out", 32'h2e, lvl2);
        $display("reset and levels done");
        for (i = 0; i < 10; i++) begin
            apb(1, 10'h0e0, {24'h0, rows[i][23:16]}, 4'h1);
            pins(rows[i]);
        end
        $display("selector rows done");
        apb(0, 10'h0dc, 0, 4'hf);
        cmp("version", 32'h5a, rd);
        apb(1, 10'h0dc, 32'ha5, 4'h1);
        apb(0, 10'h0dc, 0, 4'hf);
        cmp("version kept", 32'h5a, rd);
        apb(0, 10'h0ec, 0, 4'hf);
        cmp("unmapped err", 1, er);
        apb(1, 10'h0e0, 32'hab, 4'h0);
        pins(24'h000000);
        @(posedge clock);
        {tx, rx, sub, r106, choice} <= 7'h38;
        apb(1, 10'h0e0, 32'hcd, 4'h1);
        pins(24'h00d000);
        apb(1, 10'h0e0, 32'hef, 4'h1);
        pins(24'h00c000);
        @(posedge clock);
        tbus <= 8'h01;
        pins(24'h00d000);
        $display("version, errors and sources done");
        @(posedge clock);
        rst_b <= 0;
        repeat (2) @(posedge clock);
        rst_b <= 1;
        apb(0, 10'h0e0, 0, 4'hf);
        cmp("select rereset", 32'h0, rd);
        cmp("level rereset", 32'h0, lvl1);
        pins(24'h000000);
        $display("second reset done");
        test_done;
    end
endmodule
